// ### core/field_emitter.sv
// Serialises one packet field as binary bytes or hex text closed by CR
`timescale 1ns/10ps
`include "io_sample_cfg.svh"
module field_emitter
  import io_sample_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [15:0] value,
  input  wire logic        two_byte,
  input  wire logic        text,
  input  wire logic        to_radio,
  input  wire logic        final_field,
  input  wire logic        ser_ready,
  input  wire logic        rf_ready,
  output logic             ser_valid,
  output logic             rf_valid,
  output logic [7:0]       out_data,
  output logic             out_last,
  output logic             done
);
  logic [15:0] val_r;
  logic [2:0]  remain_r;
  logic        text_r;
  logic        final_r;

  function automatic logic [7:0] hex_char(input logic [3:0] nib);
    hex_char = (nib > `DIGIT_LIMIT) ? ({4'h0, nib} + `ASCII_ALPHA_OFFSET)
                                    : ({4'h0, nib} + `ASCII_ZERO);
  endfunction

  // Half-size fields are left-aligned so the first character is always at the top
  wire [15:0] load_val  = two_byte ? value : {value[7:0], 8'h00};
  wire [2:0]  load_cnt  = text ? (two_byte ? 3'h4 : 3'h2) : (two_byte ? 3'h1 : 3'h0);
  wire [7:0]  load_char = text ? hex_char(load_val[15:12]) : load_val[15:8];
  wire        take      = (ser_valid & ser_ready) | (rf_valid & rf_ready);
  wire [15:0] val_nxt   = text_r ? {val_r[11:0], 4'h0} : {val_r[7:0], 8'h00};
  wire [7:0]  next_char = (text_r && remain_r == 3'h1) ? `TEXT_TERMINATOR
                        : (text_r ? hex_char(val_nxt[15:12]) : val_nxt[15:8]);
  wire        last_nxt  = final_r && remain_r == 3'h1;

  always_ff @(posedge clk) begin
    if (rst) begin
      val_r     <= 16'h0000;
      remain_r  <= 3'h0;
      text_r    <= 1'b0;
      final_r   <= 1'b0;
      ser_valid <= 1'b0;
      rf_valid  <= 1'b0;
      out_data  <= 8'h00;
      out_last  <= 1'b0;
      done      <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        val_r     <= load_val;
        remain_r  <= load_cnt;
        text_r    <= text;
        final_r   <= final_field;
        out_data  <= load_char;
        out_last  <= final_field && load_cnt == 3'h0;
        ser_valid <= ~to_radio;
        rf_valid  <= to_radio;
      end else if (take) begin
        if (remain_r == 3'h0) begin
          ser_valid <= 1'b0;
          rf_valid  <= 1'b0;
          out_last  <= 1'b0;
          done      <= 1'b1;
        end else begin
          val_r    <= val_nxt;
          remain_r <= remain_r - 3'h1;
          out_data <= next_char;
          out_last <= last_nxt;
        end
      end
    end
  end
endmodule // field_emitter

// ### core/io_sample_cfg.svh
// Constants for the IO sample packet builder
`ifndef IO_SAMPLE_CFG_SVH
`define IO_SAMPLE_CFG_SVH
`define SAMPLE_SET_COUNT     16'h0001
`define DIGITAL_MASK_VALID   16'h1CFF
`define SUPPLY_BIT           7
`define ANALOG_FIELD_BASE    4'h4
`define SUPPLY_FIELD         4'h8
`define FIELD_COUNT          9
`define TEXT_TERMINATOR      8'h0D
`define ASCII_ZERO           8'h30
`define ASCII_ALPHA_OFFSET   8'h37
`define DIGIT_LIMIT          4'h9
`endif

// ### core/io_sample_packet_builder.sv
// Builds an IO sample packet on a query and sends it to the serial port or radio
`timescale 1ns/10ps
`include "io_sample_cfg.svh"
// Overview of operation
// - Digital mask: bits 0-7 and 10-12 are lines, bits 8-9 always zero.
// - Analog mask: bits 0-3 for analog inputs, bit 7 for supply voltage.
// - Digital state word comes first, only when some line is digital.
// - One two-byte word per enabled analog channel; disabled channels send nothing.
// - Analog words ascend from input zero to three, supply word last.
// - Analog words carry a 10-bit reading, zero is 0 V, full scale 1.2 V.
// - A local or remote query samples all enabled channels into one packet.
// - A local query answers through the serial port.
// - A remote query alone answers over the radio to the requesting node; with a local query in the same cycle it answers on serial.
// - Text mode sends each field as hex digits ended by carriage return.
// - Framed mode sends the packet bytes as command data of a response.
// - The leading sample-set count byte is always one.
// - Supply word included only if supply at or below a nonzero threshold.
module io_sample_packet_builder
  import io_sample_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        query_local,
  input  wire logic        query_remote,
  input  wire logic        framed_mode,
  input  wire logic [15:0] digital_enable,
  input  wire logic [3:0]  analog_enable,
  input  wire logic [15:0] line_state,
  input  wire logic [9:0]  analog_input_zero,
  input  wire logic [9:0]  analog_input_one,
  input  wire logic [9:0]  analog_input_two,
  input  wire logic [9:0]  analog_input_three,
  input  wire logic [9:0]  supply_reading,
  input  wire logic [9:0]  supply_threshold,
  input  wire logic        ser_ready,
  input  wire logic        rf_ready,
  output logic             ser_valid,
  output logic             rf_valid,
  output logic [7:0]       out_data,
  output logic             out_last,
  output logic             frame_data_start,
  output logic             busy
);
  build_state_t state_r;
  field_idx_t   fld_r;
  logic [15:0]  dmask_r;
  logic [7:0]   amask_r;
  logic [15:0]  dstate_r;
  logic [9:0]   ain_r [4];
  logic [9:0]   supply_r;
  logic [8:0]   present_r;
  logic         radio_r;
  logic         text_r;
  logic         start_r;
  logic         em_done;

  function automatic logic [15:0] analog_word(input logic [9:0] rd);
    analog_word = {6'h00, rd};
  endfunction

  // Snapshot decode taken at the query
  wire        query     = query_local | query_remote;
  wire [15:0] dmask_nxt = digital_enable & `DIGITAL_MASK_VALID;
  wire        supply_in = supply_threshold != 10'h000
                        && supply_reading <= supply_threshold;
  wire [7:0]  amask_nxt = {supply_in, 3'h0, analog_enable};
  // Field order: count, dmask, amask, state, analog_input_zero..3, supply
  wire [8:0]  pres_nxt  = {supply_in, analog_enable, dmask_nxt != 16'h0000, 3'h7};

  wire [15:0] fval =
      (fld_r == 4'h0) ? `SAMPLE_SET_COUNT :
      (fld_r == 4'h1) ? dmask_r :
      (fld_r == 4'h2) ? {8'h00, amask_r} :
      (fld_r == 4'h3) ? (dstate_r & dmask_r) :
      (fld_r == `SUPPLY_FIELD) ? analog_word(supply_r) :
      analog_word(ain_r[2'(fld_r - `ANALOG_FIELD_BASE)]);
  wire        two_byte  = fld_r != 4'h0 && fld_r != 4'h2;
  wire        fld_here  = present_r[fld_r];
  wire [8:0]  later     = present_r >> (fld_r + 4'h1);
  wire        is_final  = later == 9'h000;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r          <= BLD_IDLE;
      fld_r            <= 4'h0;
      dmask_r          <= 16'h0000;
      amask_r          <= 8'h00;
      dstate_r         <= 16'h0000;
      supply_r         <= 10'h000;
      present_r        <= 9'h000;
      radio_r          <= 1'b0;
      text_r           <= 1'b0;
      start_r          <= 1'b0;
      busy             <= 1'b0;
      frame_data_start <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        ain_r[i] <= 10'h000;
      end
    end else begin
      start_r          <= 1'b0;
      frame_data_start <= 1'b0;
      unique case (state_r)
        BLD_IDLE: begin
          if (query) begin
            dmask_r   <= dmask_nxt;
            amask_r   <= amask_nxt;
            dstate_r  <= line_state;
            supply_r  <= supply_reading;
            ain_r[0]  <= analog_input_zero;
            ain_r[1]  <= analog_input_one;
            ain_r[2]  <= analog_input_two;
            ain_r[3]  <= analog_input_three;
            present_r <= pres_nxt;
            radio_r   <= ~query_local;
            text_r    <= query_local & ~framed_mode;
            fld_r     <= 4'h0;
            busy      <= 1'b1;
            frame_data_start <= query_local & framed_mode | ~query_local;
            state_r   <= BLD_SEND;
          end
        end
        BLD_SEND: begin
          if (fld_here) begin
            start_r <= 1'b1;
            state_r <= BLD_WAIT;
          end else begin
            fld_r <= fld_r + 4'h1;
          end
        end
        BLD_WAIT: begin
          if (em_done) begin
            if (is_final) begin
              busy    <= 1'b0;
              state_r <= BLD_IDLE;
            end else begin
              fld_r   <= fld_r + 4'h1;
              state_r <= BLD_SEND;
            end
          end
        end
      endcase
    end
  end

  field_emitter u_emitter (
    .clk         (clk),
    .rst         (rst),
    .start       (start_r),
    .value       (fval),
    .two_byte    (two_byte),
    .text        (text_r),
    .to_radio    (radio_r),
    .final_field (is_final),
    .ser_ready   (ser_ready),
    .rf_ready    (rf_ready),
    .ser_valid   (ser_valid),
    .rf_valid    (rf_valid),
    .out_data    (out_data),
    .out_last    (out_last),
    .done        (em_done)
  );
endmodule // io_sample_packet_builder

// ### core/io_sample_pkg.sv
// Types shared by the IO sample packet builder
package io_sample_pkg;
  typedef enum logic [1:0] {
    BLD_IDLE,
    BLD_SEND,
    BLD_WAIT
  } build_state_t;
  typedef logic [3:0] field_idx_t;
endpackage

// ### tb/io_sample_chk.sv
// Port checker for the IO sample packet builder
`timescale 1ns/10ps
module io_sample_chk (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       query_local,
  input wire logic       query_remote,
  input wire logic       framed_mode,
  input wire logic       ser_ready,
  input wire logic       rf_ready,
  input wire logic       ser_valid,
  input wire logic       rf_valid,
  input wire logic [7:0] out_data,
  input wire logic       out_last,
  input wire logic       frame_data_start,
  input wire logic       busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence take_s; !busy && (query_local || query_remote); endsequence
  sequence bin_s; take_s ##0 (!query_local || framed_mode); endsequence
  busy_set_a: assert property (take_s |=> busy) else $error("busy not raised");
  local_ser_a: assert property (take_s ##0 query_local |-> ##3 ser_valid && !rf_valid)
    else $error("local reply not on serial");
  remote_rf_a: assert property (take_s ##0 !query_local |-> ##3 rf_valid && !ser_valid)
    else $error("remote reply not on radio");
  count_byte_a: assert property (bin_s |-> ##3 out_data == 8'h01)
    else $error("count byte wrong");
  text_digit_a: assert property (take_s ##0 query_local && !framed_mode |-> ##3 out_data == 8'h30)
    else $error("text reply start wrong");
  frame_open_a: assert property (bin_s |=> frame_data_start ##1 !frame_data_start)
    else $error("frame start pulse wrong");
  ser_hold_a: assert property (ser_valid && !ser_ready |=> ser_valid && $stable(out_data))
    else $error("serial byte not held");
  rf_hold_a: assert property (rf_valid && !rf_ready |=> rf_valid && $stable(out_data))
    else $error("radio byte not held");
  last_idle_a: assert property (out_last && (ser_valid && ser_ready || rf_valid && rf_ready) |-> ##[1:2] !busy)
    else $error("busy after last byte");
endmodule // io_sample_chk

bind io_sample_packet_builder io_sample_chk u_chk (.clk(clk), .rst(rst),
  .query_local(query_local), .query_remote(query_remote), .framed_mode(framed_mode),
  .ser_ready(ser_ready), .rf_ready(rf_ready), .ser_valid(ser_valid), .rf_valid(rf_valid),
  .out_data(out_data), .out_last(out_last), .frame_data_start(frame_data_start), .busy(busy));

// ### tb/io_sample_packet_builder_tb.sv
// Self-checking bench for the IO sample packet builder
`timescale 1ns/10ps
module io_sample_packet_builder_tb;
  typedef struct packed {
    logic loc, rem, frm, rf; logic [15:0] de; logic [3:0] ae; logic [9:0] thr;
  } row_t;
  localparam logic [9:0] AIN [4] = '{10'h3D0, 10'h124, 10'h3FF, 10'h000};
  localparam logic [9:0] SUP = 10'h200;
  row_t rows [4] = '{'{1'b1, 1'b1, 1'b1, 1'b0, 16'hFFFF, 4'hF, 10'h3FF},
    '{1'b1, 1'b0, 1'b0, 1'b0, 16'h002F, 4'h5, 10'h000},
    '{1'b0, 1'b1, 1'b0, 1'b1, 16'h0000, 4'hA, 10'h200},
    '{1'b1, 1'b0, 1'b1, 1'b0, 16'h0000, 4'h0, 10'h1FF}};
  logic clk, rst, query_local, query_remote, framed_mode, slow, txt, sup;
  logic ser_ready, rf_ready, ser_valid, rf_valid, out_last, frame_data_start, busy;
  logic [15:0] digital_enable, line_state, msk;
  logic [3:0]  analog_enable;
  logic [9:0]  supply_threshold;
  logic [7:0]  out_data;
  logic [7:0]  exp_q[$];
  row_t        r;
  int          n_fail, compares;
  io_sample_packet_builder u_io_sample_packet_builder (.clk(clk), .rst(rst),
    .query_local(query_local), .query_remote(query_remote), .framed_mode(framed_mode),
    .digital_enable(digital_enable), .analog_enable(analog_enable), .line_state(line_state),
    .analog_input_zero(AIN[0]), .analog_input_one(AIN[1]), .analog_input_two(AIN[2]),
    .analog_input_three(AIN[3]), .supply_reading(SUP), .supply_threshold(supply_threshold),
    .ser_ready(ser_ready), .rf_ready(rf_ready), .ser_valid(ser_valid), .rf_valid(rf_valid),
    .out_data(out_data), .out_last(out_last), .frame_data_start(frame_data_start), .busy(busy));
  sample_sink u_sample_sink (.clk(clk), .slow(slow), .ser_valid(ser_valid),
    .rf_valid(rf_valid), .out_data(out_data), .out_last(out_last), .ser_ready(ser_ready),
    .rf_ready(rf_ready));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction
  task automatic put(input logic [15:0] v, input int nb);
    if (txt) begin
      for (int k = 2 * nb - 1; k >= 0; k--) exp_q.push_back(hx(v[k*4 +: 4]));
      exp_q.push_back(8'h0D);
    end else for (int k = nb - 1; k >= 0; k--) exp_q.push_back(v[k*8 +: 8]);
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #100000;
    n_fail++;
    wrap_up;
  end
  initial begin
    {rst, query_local, query_remote, framed_mode, slow} = 5'h10;
    {digital_enable, line_state, analog_enable, supply_threshold} = '0;
    n_fail = 0;
    compares = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk) chk("idle", {busy, ser_valid, rf_valid, out_last, frame_data_start}, 0);
    foreach (rows[i]) begin
      @(posedge clk);
      r = rows[i];
      {query_local, query_remote, framed_mode} <= {r.loc, r.rem, r.frm};
      {digital_enable, analog_enable, supply_threshold} <= {r.de, r.ae, r.thr};
      line_state <= 16'hFFFF << i;
      slow <= ~i[0];
      @(posedge clk);
      {query_local, query_remote} <= 2'b00;
      repeat (4) @(posedge clk);
      query_local <= 1'b1; // Refused while busy
      @(posedge clk);
      query_local <= 1'b0;
      repeat (300) begin
        @(negedge clk);
        if (busy === 1'b0) break;
      end
      txt = r.loc & ~r.frm;
      msk = r.de & 16'h1CFF;
      sup = (r.thr != 0) && (SUP <= r.thr);
      put(16'h0001, 1);
      put(msk, 2);
      put({8'h00, sup, 3'b000, r.ae}, 1);
      if (msk != 0) put(line_state & msk, 2);
      for (int c = 0; c < 4; c++) if (r.ae[c]) put({6'h00, AIN[c]}, 2);
      if (sup) put({6'h00, SUP}, 2);
      chk("length", 16'(u_sample_sink.got.size()), 16'(exp_q.size()));
      foreach (exp_q[k]) chk("byte", 16'(u_sample_sink.got[k]),
        {6'h00, k == exp_q.size() - 1, r.rf, exp_q[k]});
      u_sample_sink.got.delete();
      exp_q.delete();
    end
    // Reset in the middle of a remote reply
    @(posedge clk);
    query_remote <= 1'b1;
    @(posedge clk);
    query_remote <= 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk) chk("busy", {15'h0000, busy}, 16'h0001);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk) chk("reset", {busy, ser_valid, rf_valid, out_last, frame_data_start}, 0);
    u_sample_sink.got.delete();
    wrap_up;
  end
endmodule // io_sample_packet_builder_tb

// ### tb/sample_sink.sv
// Byte sink standing for the serial host and the radio link
`timescale 1ns/10ps
module sample_sink (
  input  wire logic       clk,
  input  wire logic       slow,
  input  wire logic       ser_valid,
  input  wire logic       rf_valid,
  input  wire logic [7:0] out_data,
  input  wire logic       out_last,
  output logic            ser_ready,
  output logic            rf_ready
);
  logic [9:0] got[$];
  logic       rdy_r;
  initial rdy_r = 1'b0;
  assign ser_ready = rdy_r;
  assign rf_ready  = rdy_r;
  // Slow mode stalls every other cycle; bit 8 records the radio side, bit 9 the last mark
  always @(posedge clk) begin
    if ((ser_valid | rf_valid) & rdy_r) got.push_back({out_last, rf_valid, out_data});
    rdy_r <= slow ? ~rdy_r : 1'b1;
  end
endmodule // sample_sink
